/* core/spi_nv_mem.sv */
// spi slave front end and 2048 x 8 byte array, with an axi4-lite side port
// assumes spi pins arrive asynchronously and are much slower than core_clk
`timescale 1ns/1ps

module spi_nv_mem (
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire spi_nv_pkg::axi_req_s axi_req,
    output      spi_nv_pkg::axi_rsp_s axi_rsp,
    input  wire logic                 cs_n,
    input  wire logic                 sclk,
    input  wire logic                 hold_n,
    input  wire logic                 wp_n,
    input  wire logic                 sdi,
    output      logic                 sdo,
    output      logic                 sdo_oe_n
);
    import spi_nv_pkg::*;

    logic [PIN_N-1:0]  pin_raw;
    logic [PIN_N-1:0]  pin_s1_q;
    logic [PIN_N-1:0]  pin_s2_q;
    logic              sclk_prev_q;
    logic              sel_q;
    logic              link_en_q;
    spi_state_e        state_q;
    logic [2:0]        bit_cnt_q;
    logic [6:0]        rx_sh_q;
    logic [7:0]        tx_sh_q;
    logic [ADDR_W-1:0] addr_q;
    logic              wel_q;
    logic              wr_done_q;
    logic              wpen_q;
    logic [1:0]        bp_q;
    logic              sdo_q;
    logic              oe_n_q;
    logic [7:0]        mem [MEM_DEPTH];
    axi_rsp_s          rsp_q;
    logic              aw_got_q;
    logic              w_got_q;
    logic [AXI_AW-1:0] waddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;

    assign pin_raw = {sdi, wp_n, hold_n, sclk, cs_n};

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_q <= {PIN_N{1'b1}};
            pin_s2_q <= {PIN_N{1'b1}};
        end
        else
        begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end

    wire cs_s   = pin_s2_q[PIN_CS];
    wire sclk_s = pin_s2_q[PIN_SCK];
    wire hold_s = pin_s2_q[PIN_HOLD];
    wire wp_s   = pin_s2_q[PIN_WP];
    wire sdi_s  = pin_s2_q[PIN_SDI];

    // select and clock edges count only while hold is released
    wire want_sel = ~cs_s & link_en_q;
    wire start    = hold_s & want_sel & ~sel_q;
    wire stop     = hold_s & ~want_sel & sel_q;
    wire active   = sel_q & hold_s & want_sel;
    wire rise     = active & sclk_s & ~sclk_prev_q;
    wire fall     = active & ~sclk_s & sclk_prev_q;
    wire byte_end = rise & (bit_cnt_q == 3'd7);
    wire [7:0] rx_byte = {rx_sh_q, sdi_s};

    wire [7:0] stat_byte = {wpen_q, 3'b000, bp_q, wel_q, 1'b0};
    wire [ADDR_W-1:0] lo_addr = {addr_q[10:8], rx_byte};
    wire [ADDR_W-1:0] rd_addr = (state_q == ST_ADDR_LO) ? lo_addr : addr_q;
    wire [7:0] rd_byte = mem[rd_addr];
    wire [ADDR_W-1:0] next_addr = rd_addr + 11'd1;

    wire mem_we = byte_end & (state_q == ST_MEM_WR) & wel_q
                & ~is_protected(bp_q, addr_q);
    wire stat_we = byte_end & (state_q == ST_STAT_WR) & wel_q & wp_s;
    wire reading = (state_q == ST_MEM_RD) | (state_q == ST_STAT_RD);
    wire drive_ok = active & reading;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_prev_q <= 1'b0;
            sel_q       <= 1'b0;
        end
        else
        begin
            sclk_prev_q <= sclk_s;
            if (hold_s)
            begin
                sel_q <= want_sel;
            end
        end
    end

    // command sequencer; mode 0 and 3 differ only in idle level, so no mode state
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q   <= ST_IGNORE;
            bit_cnt_q <= 3'd0;
            rx_sh_q   <= 7'h00;
            addr_q    <= 11'h000;
            wr_done_q <= 1'b0;
        end
        else if (start)
        begin
            state_q   <= ST_OPCODE;
            bit_cnt_q <= 3'd0;
            wr_done_q <= 1'b0;
        end
        else if (rise)
        begin
            rx_sh_q   <= rx_byte[6:0];
            bit_cnt_q <= bit_cnt_q + 3'd1;
            if (byte_end)
            begin
                unique case (state_q)
                    ST_OPCODE:
                    begin
                        unique case (rx_byte)
                            OP_STAT_RD: state_q <= ST_STAT_RD;
                            OP_STAT_WR: state_q <= ST_STAT_WR;
                            OP_MEM_RD:  state_q <= ST_ADDR_HI;
                            OP_MEM_WR:  state_q <= ST_ADDR_HI;
                            default:    state_q <= ST_IGNORE;
                        endcase
                        wr_done_q <= (rx_byte == OP_MEM_WR);
                    end
                    ST_ADDR_HI:
                    begin
                        addr_q[10:8] <= rx_byte[2:0];
                        state_q      <= ST_ADDR_LO;
                    end
                    ST_ADDR_LO:
                    begin
                        state_q <= wr_done_q ? ST_MEM_WR : ST_MEM_RD;
                        addr_q  <= wr_done_q ? lo_addr : next_addr;
                    end
                    ST_MEM_RD:  addr_q <= next_addr;
                    ST_MEM_WR:  addr_q <= next_addr;
                    ST_STAT_WR:
                    begin
                        wr_done_q <= 1'b1;
                        state_q   <= ST_IGNORE;
                    end
                    ST_STAT_RD: state_q <= ST_STAT_RD;
                    ST_IGNORE:  state_q <= ST_IGNORE;
                endcase
            end
        end
    end

    // write latch and status bits; rst_n clears wel, wpen and bp alike
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wel_q  <= 1'b0;
            wpen_q <= 1'b0;
            bp_q   <= 2'b00;
        end
        else
        begin
            if (byte_end & (state_q == ST_OPCODE) & (rx_byte == OP_LATCH_SET))
            begin
                wel_q <= 1'b1;
            end
            else if (byte_end & (state_q == ST_OPCODE) & (rx_byte == OP_LATCH_CLR))
            begin
                wel_q <= 1'b0;
            end
            else if (stop & wr_done_q)
            begin
                wel_q <= 1'b0;
            end
            if (stat_we)
            begin
                wpen_q <= rx_byte[SR_WPEN];
                bp_q   <= {rx_byte[SR_BP_HI], rx_byte[SR_BP_LO]};
            end
        end
    end

    // array has no reset; each byte lands on its last bit
    always_ff @(posedge core_clk)
    begin
        if (mem_we)
        begin
            mem[addr_q] <= rx_byte;
        end
    end

    // output shifter: load at byte boundary, shift out on falling edges
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_sh_q <= 8'h00;
            sdo_q   <= 1'b0;
            oe_n_q  <= 1'b1;
        end
        else
        begin
            if (byte_end & (state_q == ST_OPCODE) & (rx_byte == OP_STAT_RD))
            begin
                tx_sh_q <= stat_byte;
            end
            else if (byte_end & (state_q == ST_STAT_RD))
            begin
                tx_sh_q <= stat_byte;
            end
            else if (byte_end & (state_q == ST_ADDR_LO) & ~wr_done_q)
            begin
                tx_sh_q <= rd_byte;
            end
            else if (byte_end & (state_q == ST_MEM_RD))
            begin
                tx_sh_q <= rd_byte;
            end
            else if (fall & reading)
            begin
                sdo_q   <= tx_sh_q[7];
                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            end
            if (!drive_ok)
            begin
                oe_n_q <= 1'b1;
            end
            // a read slot with the clock low owes a bit; also re-drives it after hold
            else if (~sclk_s)
            begin
                oe_n_q <= 1'b0;
            end
        end
    end

    assign sdo      = sdo_q;
    assign sdo_oe_n = oe_n_q;

    // axi4-lite slave
    wire aw_hs = axi_req.awvalid & rsp_q.awready;
    wire w_hs  = axi_req.wvalid & rsp_q.wready;
    wire ar_hs = axi_req.arvalid & rsp_q.arready;
    wire do_wr = aw_got_q & w_got_q & ~rsp_q.bvalid;
    wire wr_ctrl = reg_hit(waddr_q, REG_CTRL);
    wire wr_ok   = wr_ctrl | reg_hit(waddr_q, REG_STAT) | reg_hit(waddr_q, REG_ADDR);
    wire rd_ctrl = reg_hit(axi_req.araddr, REG_CTRL);
    wire rd_stat = reg_hit(axi_req.araddr, REG_STAT);
    wire rd_adr  = reg_hit(axi_req.araddr, REG_ADDR);
    wire [31:0] stat_word = {22'h000000, ~hold_s, sel_q, stat_byte};
    wire [31:0] rd_word = rd_ctrl ? {31'h00000000, link_en_q}
                        : rd_stat ? stat_word
                        : rd_adr  ? {21'h000000, addr_q}
                        : 32'h00000000;
    wire rd_ok = rd_ctrl | rd_stat | rd_adr;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsp_q     <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            waddr_q   <= 8'h00;
            wdata_q   <= 32'h00000000;
            wstrb_q   <= 4'h0;
            link_en_q <= CTRL_EN_RST;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_got_q      <= 1'b1;
                waddr_q       <= axi_req.awaddr;
                rsp_q.awready <= 1'b0;
            end
            if (w_hs)
            begin
                w_got_q      <= 1'b1;
                wdata_q      <= axi_req.wdata;
                wstrb_q      <= axi_req.wstrb;
                rsp_q.wready <= 1'b0;
            end
            if (do_wr)
            begin
                if (wr_ctrl & wstrb_q[0])
                begin
                    link_en_q <= wdata_q[CTRL_EN];
                end
                aw_got_q    <= 1'b0;
                w_got_q     <= 1'b0;
                rsp_q.bvalid <= 1'b1;
                rsp_q.bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (rsp_q.bvalid & axi_req.bready)
            begin
                rsp_q.bvalid  <= 1'b0;
                rsp_q.awready <= 1'b1;
                rsp_q.wready  <= 1'b1;
            end
            if (ar_hs)
            begin
                rsp_q.arready <= 1'b0;
                rsp_q.rvalid  <= 1'b1;
                rsp_q.rdata   <= rd_word;
                rsp_q.rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (rsp_q.rvalid & axi_req.rready)
            begin
                rsp_q.rvalid  <= 1'b0;
                rsp_q.arready <= 1'b1;
            end
        end
    end

    assign axi_rsp = rsp_q;

endmodule : spi_nv_mem

/* pkg/spi_nv_pkg.sv */
// constants, types and helpers for the serial byte memory with spi front end
// assumes a single 25 MHz core clock and an axi4-lite master for the side registers
package spi_nv_pkg;

    localparam int          ADDR_W        = 11;
    localparam int          MEM_DEPTH     = 2048;
    localparam int          BYTE_W        = 8;

    // command bytes
    localparam logic [7:0]  OP_LATCH_SET  = 8'h06;
    localparam logic [7:0]  OP_LATCH_CLR  = 8'h04;
    localparam logic [7:0]  OP_STAT_RD    = 8'h05;
    localparam logic [7:0]  OP_STAT_WR    = 8'h01;
    localparam logic [7:0]  OP_MEM_RD     = 8'h03;
    localparam logic [7:0]  OP_MEM_WR     = 8'h02;

    // status byte layout
    localparam int          SR_WPEN       = 7;
    localparam int          SR_BP_HI      = 3;
    localparam int          SR_BP_LO      = 2;
    localparam int          SR_WEL        = 1;

    // block protect boundaries
    localparam logic [10:0] PROT_QUARTER  = 11'h600;
    localparam logic [10:0] PROT_HALF     = 11'h400;

    // synchronised pin vector positions
    localparam int          PIN_CS        = 0;
    localparam int          PIN_SCK       = 1;
    localparam int          PIN_HOLD      = 2;
    localparam int          PIN_WP        = 3;
    localparam int          PIN_SDI       = 4;
    localparam int          PIN_N         = 5;

    // axi4-lite register map
    localparam int          AXI_AW        = 8;
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_STAT      = 8'h04;
    localparam logic [7:0]  REG_ADDR      = 8'h08;
    localparam int          CTRL_EN       = 0;
    localparam logic        CTRL_EN_RST   = 1'b1;
    localparam int          STAT_SEL      = 8;
    localparam int          STAT_HOLD     = 9;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef struct packed {
        logic [AXI_AW-1:0] awaddr;
        logic              awvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              wvalid;
        logic              bready;
        logic [AXI_AW-1:0] araddr;
        logic              arvalid;
        logic              rready;
    } axi_req_s;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } axi_rsp_s;

    typedef enum logic [2:0] {
        ST_OPCODE,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_MEM_RD,
        ST_MEM_WR,
        ST_STAT_RD,
        ST_STAT_WR,
        ST_IGNORE
    } spi_state_e;

    // true when the block protect setting forbids writing this location
    function automatic logic is_protected(input logic [1:0] bp, input logic [10:0] a);
        logic r;
        r = 1'b0;
        unique case (bp)
            2'b00: r = 1'b0;
            2'b01: r = (a >= PROT_QUARTER);
            2'b10: r = (a >= PROT_HALF);
            2'b11: r = 1'b1;
        endcase
        return r;
    endfunction : is_protected

    // true when an axi address selects the given register word
    function automatic logic reg_hit(input logic [AXI_AW-1:0] a, input logic [7:0] off);
        return (a[AXI_AW-1:2] == off[AXI_AW-1:2]);
    endfunction : reg_hit

endpackage : spi_nv_pkg

/* verification/spi_host.sv */
// spi master model standing in for the host controller
// assumes the device oversamples the pins; serial clock period 320 ns
`timescale 1ns/1ps
module spi_host (
    output logic      cs_n,
    output logic      sclk,
    output logic      hold_n,
    output logic      wp_n,
    output logic      sdi,
    input  wire logic sdo,
    input  wire logic sdo_oe_n
);
    logic last;
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        hold_n = 1'b1;
        wp_n = 1'b1;
        sdi = 1'b0;
        last = 1'b0;
    end
    // n bytes of tx msb first; m3 idles the clock high; hold is taken before bit hb
    task automatic frame(input int n, input logic [39:0] tx, input bit m3, input int hb,
                         output logic [39:0] rx);
        rx = '0;
        sclk <= m3;
        #160 cs_n <= 1'b0;
        #160;
        for (int i = 0; i < 8 * n; i++)
        begin
            sclk <= 1'b0;
            sdi <= tx[39 - i];
            if (i == hb)
            begin
                #40 hold_n <= 1'b0;
                sdi <= ~sdi;
                #160 sclk <= 1'b1;
                #160 sclk <= 1'b0;
                #160 hold_n <= 1'b1;
                sdi <= tx[39 - i];
            end
            #160 sclk <= 1'b1;
            // a released line reads as the inverse of what it last showed
            last = sdo_oe_n ? ~last : sdo;
            rx[39 - i] = last;
            #160;
        end
        if (!m3)
            sclk <= 1'b0;
        #160 cs_n <= 1'b1;
        sdi <= ~sdi;
        #480;
    endtask : frame
endmodule : spi_host

/* verification/spi_nv_mem_props.sv */
// concurrent checks on the ports of the spi byte memory
// assumes core_clk runs well above the serial clock and one reset domain
`timescale 1ns/1ps
module spi_nv_mem_props (
    input wire logic                 core_clk,
    input wire logic                 rst_n,
    input wire spi_nv_pkg::axi_req_s axi_req,
    input wire spi_nv_pkg::axi_rsp_s axi_rsp,
    input wire logic                 cs_n,
    input wire logic                 sclk,
    input wire logic                 hold_n,
    input wire logic                 wp_n,
    input wire logic                 sdi,
    input wire logic                 sdo,
    input wire logic                 sdo_oe_n
);
    import spi_nv_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_wr_take;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence s_rd_take;
        axi_req.arvalid && axi_rsp.arready;
    endsequence
    sequence s_rd_bad;
        s_rd_take ##0 (axi_req.araddr[7:2] > 6'h2);
    endsequence
    property p_rst_state;
        $rose(rst_n) |-> sdo_oe_n && axi_rsp.awready && axi_rsp.arready
            && !axi_rsp.bvalid && !axi_rsp.rvalid;
    endproperty
    property p_desel;
        cs_n [*6] |-> sdo_oe_n;
    endproperty
    property p_hold;
        !hold_n [*6] |-> sdo_oe_n;
    endproperty
    property p_sdo_edge;
        (!sdo_oe_n && !cs_n && $changed(sdo)) |-> !sclk;
    endproperty
    property p_oe_start;
        $fell(sdo_oe_n) |-> !sclk && !cs_n && hold_n;
    endproperty
    property p_wr_resp;
        s_wr_take |=> !axi_rsp.awready && !axi_rsp.wready ##1 axi_rsp.bvalid;
    endproperty
    property p_rd_resp;
        s_rd_take |=> axi_rsp.rvalid && !axi_rsp.arready;
    endproperty
    property p_rd_stand;
        axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
    endproperty
    property p_rd_unmapped;
        s_rd_bad |=> axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0;
    endproperty
    a_rst_state: assert property (p_rst_state)
        else $error("outputs wrong after reset");
    a_desel: assert property (p_desel)
        else $error("output driven while deselected");
    a_hold: assert property (p_hold)
        else $error("output driven during hold");
    a_sdo_edge: assert property (p_sdo_edge)
        else $error("serial output moved while clock high");
    a_oe_start: assert property (p_oe_start)
        else $error("output enabled outside a read slot");
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response late");
    a_rd_resp: assert property (p_rd_resp)
        else $error("read response late");
    a_rd_stand: assert property (p_rd_stand)
        else $error("read data dropped before ready");
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not refused");
endmodule : spi_nv_mem_props

bind spi_nv_mem spi_nv_mem_props props (.core_clk(core_clk), .rst_n(rst_n),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .cs_n(cs_n), .sclk(sclk), .hold_n(hold_n),
    .wp_n(wp_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));

/* verification/tb.sv */
// self-checking bench for the spi byte memory and its axi4-lite port
// assumes the host model in spi_host.sv and the bound checker
`timescale 1ns/1ps
module tb;
    import spi_nv_pkg::*;
    logic        core_clk, rst_n, cs_n, sclk, hold_n, wp_n, sdi, sdo, sdo_oe_n;
    axi_req_s    req;
    axi_rsp_s    rsp;
    int          err_total, n_checks;
    logic [39:0] rx;
    logic [31:0] rd;
    logic [1:0]  rr;
    logic [10:0] pa[3] = '{11'h3FF, 11'h5FF, 11'h600};
    logic [7:0]  pv[3];

    spi_nv_mem dut (.core_clk(core_clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp),
        .cs_n(cs_n), .sclk(sclk), .hold_n(hold_n), .wp_n(wp_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe_n(sdo_oe_n));
    spi_host host (.cs_n(cs_n), .sclk(sclk), .hold_n(hold_n), .wp_n(wp_n), .sdi(sdi),
        .sdo(sdo), .sdo_oe_n(sdo_oe_n));

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        @(posedge core_clk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        while (!done)
        begin
            @(posedge core_clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid)
            begin
                r = rsp.bresp;
                req.bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do @(posedge core_clk); while (!rsp.arready);
        req.arvalid <= 1'b0;
        do @(posedge core_clk); while (!rsp.rvalid);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask : axi_rd

    task automatic op(input logic [7:0] b);
        host.frame(1, {b, 32'h0}, 1'b0, -1, rx);
    endtask : op

    task automatic stat(input logic [7:0] e, input bit m3 = 1'b0, input int hb = -1);
        host.frame(2, {OP_STAT_RD, 32'h0}, m3, hb, rx);
        chk(32'(rx[31:24]), 32'(e));
    endtask : stat

    task automatic memw(input logic [15:0] a, input logic [15:0] d, input int n);
        host.frame(3 + n, {OP_MEM_WR, a, d}, 1'b0, -1, rx);
    endtask : memw

    task automatic memr(input logic [15:0] a, input int n, input int hb = -1);
        host.frame(3 + n, {OP_MEM_RD, a, 16'h0}, 1'b0, hb, rx);
    endtask : memr

    task automatic done_test(input string s);
        $display("test %s finished", s);
    endtask : done_test

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    initial
    begin
        #2000000;
        err_total++;
        report_and_stop();
    end

    initial
    begin
        req = '0;
        err_total = 0;
        n_checks = 0;
        rst_n = 1'b0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        axi_rd(REG_CTRL, rd, rr);
        chk(rd, 32'h1);
        axi_rd(REG_STAT, rd, rr);
        chk(rd, 32'h0);
        axi_rd(8'h0C, rd, rr);
        chk(32'(rr), 32'(RESP_SLVERR));
        axi_wr(8'h10, 32'h0, rr);
        chk(32'(rr), 32'(RESP_SLVERR));
        done_test("registers");
        op(OP_LATCH_SET);
        stat(8'h02);
        op(OP_LATCH_CLR);
        stat(8'h00, 1'b1);
        host.frame(2, {8'hFF, OP_LATCH_SET, 24'h0}, 1'b0, -1, rx);
        stat(8'h00, 1'b0, 12);
        axi_wr(REG_CTRL, 32'h0, rr);
        chk(32'(rr), 32'(RESP_OKAY));
        op(OP_LATCH_SET);
        axi_wr(REG_CTRL, 32'h1, rr);
        stat(8'h00);
        done_test("commands");
        op(OP_LATCH_SET);
        memw(16'hF810, 16'h5A00, 1);
        stat(8'h00);
        memw(16'h0010, 16'hC300, 1);
        memr(16'h0010, 1);
        chk(32'(rx[15:8]), 32'h5A);
        op(OP_LATCH_SET);
        memw(16'h07FF, 16'h1122, 2);
        memr(16'h07FF, 2);
        chk(32'(rx[15:0]), 32'h1122);
        memr(16'h0000, 1, 28);
        chk(32'(rx[15:8]), 32'h22);
        done_test("memory");
        host.wp_n <= 1'b0;
        op(OP_LATCH_SET);
        host.frame(2, {OP_STAT_WR, 8'h0C, 24'h0}, 1'b0, -1, rx);
        op(OP_LATCH_CLR);
        stat(8'h00);
        host.wp_n <= 1'b1;
        for (int b = 0; b < 4; b++)
        begin
            op(OP_LATCH_SET);
            host.frame(2, {OP_STAT_WR, 4'h0, 2'(b), 2'b00, 24'h0}, 1'b0, -1, rx);
            stat({4'h0, 2'(b), 2'b00});
            for (int k = 0; k < 3; k++)
            begin
                op(OP_LATCH_SET);
                memw({5'h0, pa[k]}, {8'(16 * b + k), 8'h00}, 1);
                if (!(b == 3 || (b == 1 && pa[k] >= 11'h600) || (b == 2 && pa[k] >= 11'h400)))
                    pv[k] = 8'(16 * b + k);
                memr({5'h0, pa[k]}, 1);
                chk(32'(rx[15:8]), 32'(pv[k]));
            end
        end
        op(OP_LATCH_SET);
        host.frame(2, {OP_STAT_WR, 32'h0}, 1'b0, -1, rx);
        stat(8'h00, 1'b1);
        done_test("protection");
        report_and_stop();
    end
endmodule : tb
